// ---- shared/rxpf_pkg.sv ----
// rxpf_pkg: constants, register map and carrier types for the receive packet filter
package rxpf_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [6:0] RXPF_OFS_FIFO = 7'h00;       // rx_fifo_port
   localparam logic [6:0] RXPF_OFS_RATE_HI = 7'h03;    // chip_rate_high
   localparam logic [6:0] RXPF_OFS_RATE_LO = 7'h04;    // chip_rate_low
   localparam logic [7:0] RXPF_RST_FIFO = 8'h00;       // fifo port reads this when empty
   localparam logic [7:0] RXPF_RST_RATE_HI = 8'h1A;    // chip rate, high byte
   localparam logic [7:0] RXPF_RST_RATE_LO = 8'h0B;    // chip rate, low byte

   // ----------------------------------------------------------------
   // packet handling codes and sizes
   // ----------------------------------------------------------------
   localparam logic [1:0] RXPF_DC_MANCH = 2'h1;        // manchester decoding
   localparam logic [1:0] RXPF_DC_WHITE = 2'h2;        // de-whitening
   localparam logic RXPF_LEN_VARIABLE = 1'h1;          // frame_length_kind: variable
   localparam int RXPF_FIFO_DEPTH = 66;                // receive fifo entries
   localparam int RXPF_CRC_BYTES = 2;                  // trailing checksum bytes
   localparam logic [2:0] RXPF_BIT_LAST = 3'h7;        // last bit index in a byte

   // ----------------------------------------------------------------
   // checksum and whitening generators
   // ----------------------------------------------------------------
   localparam logic [15:0] RXPF_CRC_POLY = 16'h1021;   // ccitt polynomial
   localparam logic [15:0] RXPF_CRC_PRESET = 16'h1D0F; // nonzero preset catches leading zeros
   localparam logic [8:0] RXPF_LFSR_SEED = 9'h1FF;     // whitening seed, all ones
   localparam int RXPF_LFSR_TAP = 5;                   // x^5 tap of x^9 + x^5 + 1

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   // packet configuration bits held outside this block
   typedef struct packed {
      logic packet_mode;         // packet handling in use
      logic frame_length_kind;   // 1 variable, 0 fixed
      logic [7:0] max_payload_len; // length limit or fixed length
      logic crc_check_en;        // check trailing checksum
      logic crc_keep_on_fail;    // keep fifo on checksum failure
      logic [1:0] dc_balance_sel; // dc-free decoding choice
   } rxpf_cfg_s;

   // register access strobe group
   typedef struct packed {
      logic wr;                  // write strobe, one cycle
      logic rd;                  // read strobe, one cycle
      logic [6:0] addr;          // register offset
      logic [7:0] wdata;         // write data
   } rxpf_reg_req_s;

   // receive sequence, gray coded along idle-payload-crc-drain
   typedef enum logic [1:0] {
      RXPF_IDLE = 2'b00,
      RXPF_PAYLOAD = 2'b01,
      RXPF_CHECK = 2'b11,
      RXPF_DRAIN = 2'b10
   } rxpf_state_e;

endpackage

// ---- hdl/rxpf_skid.sv ----
// rxpf_skid: two-entry buffer between byte assembly and the receive fifo
`timescale 1ns/100ps
`default_nettype none

module rxpf_skid
   import rxpf_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic mclk,                 // system clock
   input wire logic rst,                  // synchronous reset, active high
   input wire logic clr,                  // drop everything held
   input wire logic in_valid,             // byte offered
   output logic in_ready,                 // room for a byte
   input wire logic [WIDTH-1:0] in_data,  // offered byte
   output logic out_valid,                // byte available
   input wire logic out_ready,            // fifo takes it
   output logic [WIDTH-1:0] out_data      // available byte
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] d0;      // head entry
      logic [WIDTH-1:0] d1;      // second entry
      logic v0;                  // head valid
      logic v1;                  // second valid
   } rxpf_skid_st_s;

   rxpf_skid_st_s s_q;           // registered state
   rxpf_skid_st_s s_d;           // next state

   assign in_ready = ~s_q.v1;
   assign out_valid = s_q.v0;
   assign out_data = s_q.d0;

   // next state: pop first, then fill the first free slot
   always_comb begin
      s_d = s_q;
      if (clr) begin
         // clear outranks push so a discarded frame leaves nothing
         s_d.v0 = 1'b0;
         s_d.v1 = 1'b0;
      end else begin
         if (s_q.v0 && out_ready) begin
            s_d.d0 = s_q.d1;
            s_d.v0 = s_q.v1;
            s_d.v1 = 1'b0;
         end
         if (in_valid && !s_q.v1) begin
            if (!s_d.v0) begin
               s_d.d0 = in_data;
               s_d.v0 = 1'b1;
            end else begin
               s_d.d1 = in_data;
               s_d.v1 = 1'b1;
            end
         end
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

`default_nettype wire

// ---- hdl/rxpf_top.sv ----
// rxpf_top: receive packet filter, dc-free decoder, checksum check and fifo
//
// Overview of operation
// [R1] variable length: first byte loads length counter
// [R2] accept only if length below maximum
// [R3] length byte stays in the fifo
// [R4] host sets maximum to 255 to disable; the code still rejects a length byte of 255
// [R5] checksum compared, outcome in pass flag
// [R6] failure without keep: clear fifo, no interrupt
// [R7] failure with keep: fifo kept, interrupt raised
// [R8] checksum bytes never enter the fifo
// [R9] ccitt checksum catching leading, trailing zeros
// [R10] 0x1021, preset 0x1D0F, inverted, msb first
// [R11] host enables at most one dc method
// [R12] manchester only for code 01, packet mode
// [R13] chip pair 10 gives one, 01 zero
// [R14] manchester halves user bit rate
// [R15] decoding covers payload and checksum only
// [R16] code 10 xors with 9-bit lfsr
// [R17] de-whitening keeps one bit per chip
// [R18] lfsr x^9+x^5+1, all-ones seed, per bit
// [R19] payload-available on event pin zero when complete
`timescale 1ns/100ps
`default_nettype none

module rxpf_top
   import rxpf_pkg::*;
#(
   parameter int FIFO_DEPTH = RXPF_FIFO_DEPTH
) (
   input wire logic mclk,                 // 125 MHz system clock
   input wire logic rst,                  // synchronous reset, active high
   input wire logic chip_stb,             // one recovered chip this cycle
   input wire logic chip_bit,             // chip value
   input wire logic sync_det,             // sync word just ended, pulse
   input wire logic rx_abort,             // receiver left rx, pulse
   input wire rxpf_cfg_s cfg,             // packet configuration bits
   input wire rxpf_reg_req_s reg_req,     // register access
   output logic [7:0] reg_rdata,          // read data, one cycle after rd
   output logic [15:0] chip_rate_setting, // programmed chip rate
   output logic crc_pass_flag,            // last checksum matched
   output logic event_pin_zero,           // payload_avail_irq level
   output logic overflow_flag             // frame lost to a full fifo
);

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int AW = $clog2(FIFO_DEPTH + 1);              // pointer/count width
   localparam logic [AW-1:0] DEPTH_C = AW'(FIFO_DEPTH);     // depth as pointer
   localparam logic [AW-1:0] LAST_C = AW'(FIFO_DEPTH - 1);  // last index
   localparam logic [AW-1:0] ONE_C = AW'(1);                // increment

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      rxpf_state_e st;           // receive sequence
      logic manch;               // manchester latched for frame
      logic white;               // de-whitening latched for frame
      logic crcen;               // checksum check latched
      logic keep;                // keep-on-fail latched
      logic unlim;               // unlimited length frame
      logic first;               // next byte is the length byte
      logic half;                // first chip of a pair held
      logic chip_hold;           // held first chip
      logic [8:0] lfsr;          // whitening sequence
      logic [15:0] crc;          // running checksum
      logic [7:0] sh;            // byte assembly
      logic [2:0] bitcnt;        // bit index within byte
      logic [7:0] remain;        // payload bytes still expected
      logic [15:0] rxcrc;        // received checksum bytes
      logic crc_idx;             // which checksum byte
      logic pass;                // crc_pass_flag
      logic irq;                 // payload_avail_irq
      logic ovf;                 // overflow seen
      logic [7:0] rdata;         // read data register
      logic [7:0] rate_hi;       // chip_rate_high
      logic [7:0] rate_lo;       // chip_rate_low
      logic [AW-1:0] wr;         // fifo write index
      logic [AW-1:0] rd;         // fifo read index
      logic [AW-1:0] cnt;        // fifo fill
   } rxpf_top_st_s;

   rxpf_top_st_s s_q;            // registered state
   rxpf_top_st_s s_d;            // next state
   logic [7:0] mem [FIFO_DEPTH]; // fifo storage

   // byte path through the two-entry buffer
   logic sk_in_valid;            // assembled payload byte offered
   logic [7:0] sk_in_data;       // that byte
   logic sk_in_ready;            // buffer has room
   logic sk_out_valid;           // buffer head valid
   logic [7:0] sk_out_data;      // buffer head
   logic sk_clr;                 // drop buffered bytes
   logic fifo_push;              // head moves into fifo
   logic fifo_pop;               // host read takes a byte

   // per-cycle decode signals
   logic bit_vld;                // one nrz user bit this cycle
   logic bit_val;                // its value
   logic byte_done;              // eighth bit arrived
   logic [7:0] byte_val;         // completed byte
   logic crc_fb;                 // checksum feedback bit
   logic crc_ok;                 // checksum comparison outcome

   // ----------------------------------------------------------------
   // outputs, all straight from state flops
   // ----------------------------------------------------------------
   assign reg_rdata = s_q.rdata;
   assign chip_rate_setting = {s_q.rate_hi, s_q.rate_lo};
   assign crc_pass_flag = s_q.pass;
   assign event_pin_zero = s_q.irq;
   assign overflow_flag = s_q.ovf;

   // fifo moves; full fifo back-pressures the buffer
   assign fifo_push = sk_out_valid && (s_q.cnt != DEPTH_C) && !sk_clr;
   assign fifo_pop = reg_req.rd && (reg_req.addr == RXPF_OFS_FIFO) && (s_q.cnt != '0);

   // ----------------------------------------------------------------
   // two-entry buffer in the byte path
   // ----------------------------------------------------------------
   rxpf_skid #(
      .WIDTH(8)
   ) u_skid (
      .mclk(mclk),
      .rst(rst),
      .clr(sk_clr),
      .in_valid(sk_in_valid),
      .in_ready(sk_in_ready),
      .in_data(sk_in_data),
      .out_valid(sk_out_valid),
      .out_ready(s_q.cnt != DEPTH_C),
      .out_data(sk_out_data)
   );

   // ----------------------------------------------------------------
   // chip to user bit decoding
   // ----------------------------------------------------------------
   // only payload and checksum chips reach here; sync is handled upstream
   always_comb begin
      bit_vld = 1'b0;
      bit_val = chip_bit;
      if (chip_stb && (s_q.st == RXPF_PAYLOAD || s_q.st == RXPF_CHECK)) begin
         if (s_q.manch) begin
            // [R13] [R14] pair decode, bit on second chip
            bit_vld = s_q.half;
            bit_val = s_q.chip_hold;
         end else begin
            // [R16] [R17] xor with lfsr, one bit per chip
            bit_vld = 1'b1;
            bit_val = chip_bit ^ (s_q.white & s_q.lfsr[0]);
         end
      end
      byte_done = bit_vld && (s_q.bitcnt == RXPF_BIT_LAST);
      byte_val = {s_q.sh[6:0], bit_val};
      crc_fb = s_q.crc[15] ^ bit_val;
      // [R9] [R10] inverted result compared to received bytes
      crc_ok = (s_q.rxcrc == ~s_q.crc);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      sk_in_valid = 1'b0;
      sk_in_data = byte_val;
      sk_clr = 1'b0;

      // chip pairing and bit assembly
      if (chip_stb && s_q.manch && s_q.st != RXPF_IDLE) begin
         s_d.half = ~s_q.half;
         s_d.chip_hold = chip_bit;
      end
      if (bit_vld) begin
         s_d.sh = byte_val;
         s_d.bitcnt = s_q.bitcnt + 3'h1;
         // [R18] lfsr advances once per user bit
         s_d.lfsr = {s_q.lfsr[0] ^ s_q.lfsr[RXPF_LFSR_TAP], s_q.lfsr[8:1]};
         if (s_q.st == RXPF_PAYLOAD) begin
            // [R5] [R10] msb-first checksum over payload bits
            s_d.crc = {s_q.crc[14:0], 1'b0} ^ (crc_fb ? RXPF_CRC_POLY : 16'h0000);
         end
      end

      case (s_q.st)
         RXPF_IDLE: begin
            if (sync_det && cfg.packet_mode) begin
               // [R12] manchester only for its code in packet mode
               s_d.manch = (cfg.dc_balance_sel == RXPF_DC_MANCH);
               s_d.white = (cfg.dc_balance_sel == RXPF_DC_WHITE);
               s_d.unlim = !cfg.frame_length_kind && (cfg.max_payload_len == 8'h00);
               s_d.crcen = cfg.crc_check_en && !s_d.unlim;
               s_d.keep = cfg.crc_keep_on_fail;
               s_d.first = (cfg.frame_length_kind == RXPF_LEN_VARIABLE);
               s_d.remain = cfg.max_payload_len;
               s_d.half = 1'b0;
               s_d.bitcnt = 3'h0;
               // [R18] seed each payload with all ones
               s_d.lfsr = RXPF_LFSR_SEED;
               s_d.crc = RXPF_CRC_PRESET;
               s_d.crc_idx = 1'b0;
               s_d.irq = 1'b0;
               s_d.st = RXPF_PAYLOAD;
            end
         end
         RXPF_PAYLOAD: begin
            if (byte_done) begin
               // [R3] every payload byte, length byte included, is kept unless the length is rejected or the buffer is full
               sk_in_valid = 1'b1;
               if (!sk_in_ready) begin
                  // buffer full: the stream cannot wait, so drop the frame
                  s_d.ovf = 1'b1;
                  s_d.st = RXPF_IDLE;
               end else if (s_q.first) begin
                  s_d.first = 1'b0;
                  // [R1] [R2] length byte loads counter if below maximum
                  if (byte_val >= cfg.max_payload_len) begin
                     sk_clr = 1'b1;
                     sk_in_valid = 1'b0;
                     s_d.st = RXPF_IDLE;
                  end else begin
                     s_d.remain = byte_val;
                     if (byte_val == 8'h00) begin
                        s_d.st = s_q.crcen ? RXPF_CHECK : RXPF_DRAIN;
                     end
                  end
               end else if (!s_q.unlim) begin
                  s_d.remain = s_q.remain - 8'h01;
                  if (s_q.remain == 8'h01) begin
                     s_d.st = s_q.crcen ? RXPF_CHECK : RXPF_DRAIN;
                  end
               end
            end
         end
         RXPF_CHECK: begin
            // [R8] [R15] checksum bytes decoded but never buffered
            if (byte_done) begin
               s_d.rxcrc = {s_q.rxcrc[7:0], byte_val};
               s_d.crc_idx = 1'b1;
               if (s_q.crc_idx) begin
                  s_d.st = RXPF_DRAIN;
               end
            end
         end
         RXPF_DRAIN: begin
            // wait until the last payload byte sits in the fifo
            if (!sk_out_valid) begin
               s_d.st = RXPF_IDLE;
               if (s_q.crcen) begin
                  // [R5] outcome recorded in the pass flag
                  s_d.pass = crc_ok;
               end
               if (s_q.crcen && !crc_ok && !s_q.keep) begin
                  // [R6] silent drop of the frame
                  sk_clr = 1'b1;
               end else begin
                  // [R7] [R19] payload complete, raise event pin zero
                  s_d.irq = 1'b1;
               end
            end
         end
         default: begin
            s_d.st = RXPF_IDLE;
         end
      endcase

      // leaving rx mid-frame abandons the frame, fifo kept
      if (rx_abort && s_q.st != RXPF_IDLE && s_q.st != RXPF_DRAIN) begin
         s_d.st = RXPF_IDLE;
      end

      // fifo pointers and fill
      if (fifo_push) begin
         s_d.wr = (s_q.wr == LAST_C) ? '0 : s_q.wr + ONE_C;
      end
      if (fifo_pop) begin
         s_d.rd = (s_q.rd == LAST_C) ? '0 : s_q.rd + ONE_C;
      end
      s_d.cnt = s_q.cnt + (fifo_push ? ONE_C : '0) - (fifo_pop ? ONE_C : '0);
      if (sk_clr) begin
         // [R6] discarded or failed frame empties the fifo
         s_d.wr = '0;
         s_d.rd = '0;
         s_d.cnt = '0;
      end

      // payload-available drops once the host has emptied the fifo
      if (s_q.irq && s_d.cnt == '0 && s_d.irq == s_q.irq) begin
         s_d.irq = 1'b0;
      end

      // register reads; fifo read pops the head
      s_d.rdata = RXPF_RST_FIFO;
      if (reg_req.rd) begin
         if (reg_req.addr == RXPF_OFS_FIFO) begin
            s_d.rdata = (s_q.cnt != '0) ? mem[s_q.rd] : RXPF_RST_FIFO;
         end else if (reg_req.addr == RXPF_OFS_RATE_HI) begin
            s_d.rdata = s_q.rate_hi;
         end else if (reg_req.addr == RXPF_OFS_RATE_LO) begin
            s_d.rdata = s_q.rate_lo;
         end else begin
            s_d.rdata = 8'h00;
         end
      end

      // register writes; fifo writes ignored in a receive-only part
      if (reg_req.wr) begin
         if (reg_req.addr == RXPF_OFS_RATE_HI) begin
            s_d.rate_hi = reg_req.wdata;
         end else if (reg_req.addr == RXPF_OFS_RATE_LO) begin
            s_d.rate_lo = reg_req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= RXPF_IDLE;
         s_q.lfsr <= RXPF_LFSR_SEED;
         s_q.crc <= RXPF_CRC_PRESET;
         s_q.rate_hi <= RXPF_RST_RATE_HI;
         s_q.rate_lo <= RXPF_RST_RATE_LO;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // fifo storage
   // ----------------------------------------------------------------
   // storage needs no reset; count guards every read
   always_ff @(posedge mclk) begin
      if (fifo_push) begin
         mem[s_q.wr] <= sk_out_data;
      end
   end

endmodule

`default_nettype wire

// ---- verif/rxpf_top_asserts.sv ----
// rxpf_top_asserts: port-level checks on the receive packet filter
`timescale 1ns/100ps
`default_nettype none
module rxpf_top_asserts
   import rxpf_pkg::*;
(
   input wire logic mclk,                 // system clock
   input wire logic rst,                  // sync reset
   input wire logic sync_det,             // frame start pulse
   input wire rxpf_reg_req_s reg_req,     // register access
   input wire logic [7:0] reg_rdata,      // read data
   input wire logic [15:0] chip_rate_setting, // programmed rate
   input wire logic event_pin_zero,       // payload ready level
   input wire logic overflow_flag         // sticky overflow
);
   // ------------------------------------------------
   // one domain, reset masks every check
   // ------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // a cycle with no read and no new frame
   sequence s_quiet;
      !reg_req.rd && !sync_det;
   endsequence
   property p_rd_idle;
      !reg_req.rd |=> reg_rdata == 8'h00;
   endproperty
   property p_rd_unmap;
      reg_req.rd && reg_req.addr > RXPF_OFS_RATE_LO |=> reg_rdata == 8'h00;
   endproperty
   property p_rd_rate;
      reg_req.rd && !reg_req.wr && reg_req.addr == RXPF_OFS_RATE_HI
         |=> reg_rdata == chip_rate_setting[15:8];
   endproperty
   property p_wr_hi;
      reg_req.wr && reg_req.addr == RXPF_OFS_RATE_HI
         |=> chip_rate_setting[15:8] == $past(reg_req.wdata);
   endproperty
   property p_wr_lo;
      reg_req.wr && reg_req.addr == RXPF_OFS_RATE_LO
         |=> chip_rate_setting[7:0] == $past(reg_req.wdata);
   endproperty
   property p_rate_hold;
      !reg_req.wr |=> $stable(chip_rate_setting);
   endproperty
   property p_ovf_sticky;
      overflow_flag |=> overflow_flag;
   endproperty
   // irq stands until the host reads or a new frame starts
   property p_irq_hold;
      event_pin_zero ##0 s_quiet |=> event_pin_zero;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
   a_rd_rate: assert property (p_rd_rate) else $error("rate read mismatch");
   a_wr_hi: assert property (p_wr_hi) else $error("rate high write lost");
   a_wr_lo: assert property (p_wr_lo) else $error("rate low write lost");
   a_rate_hold: assert property (p_rate_hold) else $error("rate changed without write");
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
   a_irq_hold: assert property (p_irq_hold) else $error("irq fell early");
endmodule
bind rxpf_top rxpf_top_asserts rxpf_top_asserts_inst (.mclk, .rst, .sync_det, .reg_req,
   .reg_rdata, .chip_rate_setting, .event_pin_zero, .overflow_flag);
`default_nettype wire

// ---- verif/rxpf_chip_src.sv ----
// rxpf_chip_src: demodulator model sending framed chips
`timescale 1ns/100ps
`default_nettype none
module rxpf_chip_src (
   input wire logic mclk,      // system clock
   output logic chip_stb,      // chip valid
   output logic chip_bit,      // chip value
   output logic sync_det       // sync word ended
);
   initial begin
      chip_stb = 1'b0;
      chip_bit = 1'b0;
      sync_det = 1'b0;
   end
   // gap idles between chips; idle chip line toggles, no pull on it
   task automatic send(input logic [1:0] dc, input logic [7:0] b[$], input int gap);
      logic [8:0] lf;
      logic x;
      lf = 9'h1FF;
      @(posedge mclk);
      sync_det <= 1'b1;
      @(posedge mclk);
      sync_det <= 1'b0;
      foreach (b[i]) for (int k = 7; k >= 0; k--) begin
         x = b[i][k];
         if (dc == 2'h2) begin
            x = x ^ lf[0];
            lf = {lf[0] ^ lf[5], lf[8:1]};
         end
         // manchester sends two chips a bit
         for (int n = 0; n < ((dc == 2'h1) ? 2 : 1); n++) begin
            repeat (gap) begin
               @(posedge mclk);
               chip_stb <= 1'b0;
               chip_bit <= ~chip_bit;
            end
            @(posedge mclk);
            chip_stb <= 1'b1;
            chip_bit <= (n == 0) ? x : ~x;
         end
      end
      @(posedge mclk);
      chip_stb <= 1'b0;
      chip_bit <= ~chip_bit;
   endtask
endmodule
`default_nettype wire

// ---- verif/rxpf_tb_top.sv ----
// rxpf_tb_top: frame table and register checks for the receive packet filter
`timescale 1ns/100ps
`default_nettype none
module rxpf_tb_top
   import rxpf_pkg::*;
;
   typedef struct {logic [1:0] dc; int len, mx, gap; bit crc, keep, bad; logic irq, pass;} rxpf_row_s;
   logic mclk, rst, chip_stb, chip_bit, sync_det, rx_abort;
   logic crc_pass_flag, event_pin_zero, overflow_flag;
   rxpf_cfg_s cfg;          // packet configuration
   rxpf_reg_req_s reg_req;  // register strobes
   logic [7:0] reg_rdata, d;
   logic [15:0] chip_rate_setting, c;
   logic [7:0] q[$];        // bytes of the frame on air
   int errors, checked, n;
   // dc, length, max, gap, crc, keep, corrupt, irq, pass
   // max 255 passes every length below 255
   rxpf_row_s rows[8] = '{'{2'h0, 3, 255, 0, 1, 0, 0, 1, 1}, '{RXPF_DC_MANCH, 2, 200, 0, 1, 0, 0, 1, 1},
      '{RXPF_DC_WHITE, 2, 200, 1, 1, 0, 0, 1, 1}, '{RXPF_DC_MANCH, 1, 9, 3, 0, 0, 0, 1, 0},
      '{2'h0, 2, 200, 0, 1, 1, 1, 1, 0}, '{2'h0, 2, 200, 0, 1, 0, 1, 0, 0},
      '{2'h0, 5, 5, 0, 0, 0, 0, 0, 0}, '{2'h0, 4, 5, 0, 1, 0, 0, 1, 1}};
   rxpf_top rxpf_top_inst (.mclk, .rst, .chip_stb, .chip_bit, .sync_det, .rx_abort, .cfg,
      .reg_req, .reg_rdata, .chip_rate_setting, .crc_pass_flag, .event_pin_zero, .overflow_flag);
   rxpf_chip_src rxpf_chip_src_inst (.mclk, .chip_stb, .chip_bit, .sync_det);
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task automatic finish_test;
      if (errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t byte %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t flag %b want %b", $time, got, exp);
      end
   endtask
   // data lands one cycle after the read strobe
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk);
      reg_req <= '0;
      #1 v = reg_rdata;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_req <= '{1'b1, 1'b0, a, v};
      @(posedge mclk);
      reg_req <= '0;
   endtask
   // ccitt, preset nonzero, msb first
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] r;
      r = RXPF_CRC_PRESET;
      foreach (b[i]) for (int k = 7; k >= 0; k--)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i][k]) ? RXPF_CRC_POLY : 16'h0000);
      return r;
   endfunction
   initial begin
      rst = 1'b1;
      rx_abort = 1'b0;
      reg_req = '0;
      cfg = '0;
      errors = 0;
      checked = 0;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         @(posedge mclk);
         cfg <= '{1'b1, RXPF_LEN_VARIABLE, rows[i].mx[7:0], rows[i].crc, rows[i].keep, rows[i].dc};
         q = {rows[i].len[7:0]};
         for (n = 1; n <= rows[i].len; n++) q.push_back(8'hC3 ^ n[7:0]);
         c = ~crc16(q) ^ {15'h0000, rows[i].bad};
         if (rows[i].crc) q = {q, c[15:8], c[7:0]};
         rxpf_chip_src_inst.send(rows[i].dc, q, rows[i].gap);
         repeat (8) @(posedge mclk);
         #1;
         for (n = 0; n < 40 && event_pin_zero !== rows[i].irq; n++) #8;
         if (n == 40) begin
            errors++;
            finish_test;
         end
         chk1(event_pin_zero, rows[i].irq);
         if (rows[i].crc) chk1(crc_pass_flag, rows[i].pass);
         for (n = 0; n < (rows[i].irq ? rows[i].len + 1 : 0); n++) begin
            rd(RXPF_OFS_FIFO, d);
            chk8(d, q[n]);
         end
         rd(RXPF_OFS_FIFO, d);
         chk8(d, 8'h00);
         chk1(event_pin_zero, 1'b0);
      end
      // register map, ignored and unmapped places, mid-run reset
      rd(RXPF_OFS_RATE_HI, d);
      chk8(d, RXPF_RST_RATE_HI);
      wr(RXPF_OFS_RATE_HI, 8'hA7);
      wr(RXPF_OFS_RATE_LO, 8'h5C);
      rd(RXPF_OFS_RATE_LO, d);
      chk8(d, 8'h5C);
      chk8(chip_rate_setting[15:8], 8'hA7);
      wr(RXPF_OFS_FIFO, 8'h77);
      rd(RXPF_OFS_FIFO, d);
      chk8(d, RXPF_RST_FIFO);
      rd(7'h10, d);
      chk8(d, 8'h00);
      // unlimited frame, no reads: fifo and buffer fill, frame lost
      @(posedge mclk);
      cfg <= '{1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0};
      q = {};
      for (n = 0; n < 70; n++) q.push_back(n[7:0] ^ 8'h5A);
      rxpf_chip_src_inst.send(2'h0, q, 0);
      chk1(overflow_flag, 1'b1);
      chk1(event_pin_zero, 1'b0);
      rd(RXPF_OFS_FIFO, d);
      chk8(d, q[0]);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      #1 chk8(chip_rate_setting[7:0], RXPF_RST_RATE_LO);
      chk1(crc_pass_flag, 1'b0);
      chk1(overflow_flag, 1'b0);
      finish_test;
   end
endmodule
`default_nettype wire
